// file: design/ppcc_top.sv
// profile position command control: apb registers, status word, interrupt
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module ppcc_top
   import ppcc_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [15:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   ext_stop_pin,
   input  wire logic                   motor_excited,
   input  wire logic [7:0]             drive_state_flags,
   input  wire logic                   motion_busy,
   input  wire logic                   motion_done,
   input  wire logic                   torque_limit_reached,
   input  wire logic                   following_error,
   input  wire logic                   internal_limit_active,
   input  wire logic                   target_reached,
   input  wire logic                   remote_active,
   output logic                        halt_req,
   output logic      [PPCC_STOP_W-1:0] halt_method,
   output logic      [4:0]             drive_ctl_bits,
   output logic                        wrap_select,
   output logic                        push_select,
   output logic                        incremental_origin_select,
   output logic                        launch,
   output logic                        launch_incremental,
   output logic                        launch_replace,
   output logic                        irq
);
   logic [15:0]            cmd_q,      cmd_d;
   logic [15:0]            status_q,   status_d;
   logic [PPCC_STOP_W-1:0] stop_q,     stop_d;
   logic [PPCC_IRQ_W-1:0]  istat_q,    istat_d;
   logic [PPCC_IRQ_W-1:0]  imask_q,    imask_d;
   logic [31:0]            rdata_q,    rdata_d;
   logic                   err_q,      err_d;
   logic                   setup;
   logic                   access;
   logic                   wr_cmd;
   logic                   wr_stop;
   logic                   wr_istat;
   logic                   wr_imask;
   logic [15:0]            wr_cmd_val;
   logic [PPCC_IRQ_W-1:0]  events;
   logic                   stop_pin_s;

   ppcc_start_if sif ();

   // stop pin comes from outside the clock domain
   ppcc_sync #(
      .WIDTH (1)
   ) u_stop_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (ext_stop_pin),
      .sync_out (stop_pin_s)
   );

   ppcc_start_ctrl u_start (
      .pclk    (pclk),
      .presetn (presetn),
      .sif     (sif)
   );

   // feed the start controller from the command word and drive state
   assign sif.start_bit   = cmd_q[PPCC_CMD_START];
   assign sif.immed_bit   = cmd_q[PPCC_CMD_IMMED];
   assign sif.incr_bit    = cmd_q[PPCC_CMD_INCR];
   assign sif.halt_bit    = cmd_q[PPCC_CMD_HALT];
   assign sif.stop_active = stop_pin_s;
   assign sif.op_enabled  = drive_state_flags[PPCC_DRV_OP_EN];
   assign sif.excited     = motor_excited;
   assign sif.busy        = motion_busy;
   assign sif.done        = motion_done;

   // apb phase decode; zero wait states, so pready is constant high
   assign setup      = psel & ~penable;
   assign access     = psel & penable;
   assign wr_cmd     = access & pwrite & (paddr == PPCC_OFF_CMD);
   assign wr_stop    = access & pwrite & (paddr == PPCC_OFF_STOP_CFG);
   assign wr_istat   = access & pwrite & (paddr == PPCC_OFF_IRQ_STAT);
   assign wr_imask   = access & pwrite & (paddr == PPCC_OFF_IRQ_MASK);
   assign wr_cmd_val = pwdata[15:0] & PPCC_CMD_MASK;
   assign pready     = 1'b1;
   assign pslverr    = access & err_q;

   // read data latched in setup so prdata comes from a flop in access
   always_comb begin
      rdata_d = rdata_q;
      err_d   = err_q;
      if (setup) begin
         err_d = 1'b0;
         unique case (paddr)
            PPCC_OFF_CMD:      rdata_d = {16'h0000, cmd_q};
            PPCC_OFF_STATUS:   rdata_d = {16'h0000, status_q};
            PPCC_OFF_IRQ_STAT: rdata_d = {30'h00000000, istat_q};
            PPCC_OFF_IRQ_MASK: rdata_d = {30'h00000000, imask_q};
            PPCC_OFF_STOP_CFG: rdata_d = {30'h00000000, stop_q};
            default: begin
               rdata_d = 32'h00000000;
               err_d   = 1'b1;
            end
         endcase
      end
   end

   // software state: command word, stop method, mask
   always_comb begin
      cmd_d   = cmd_q;
      stop_d  = stop_q;
      imask_d = imask_q;
      if (wr_cmd) begin
         cmd_d = wr_cmd_val;          // reserved bits 15, 11..9 read zero
      end
      if (wr_stop) begin
         stop_d = pwdata[PPCC_STOP_W-1:0];
      end
      if (wr_imask) begin
         imask_d = pwdata[PPCC_IRQ_W-1:0];
      end
   end

   // sticky events; a set in the clearing cycle survives the clear
   assign events = {sif.ignored, sif.accepted};
   always_comb begin
      istat_d = istat_q;
      if (wr_istat) begin
         istat_d = istat_q & ~pwdata[PPCC_IRQ_W-1:0];
      end
      istat_d = istat_d | events;
   end
   assign irq = |(istat_q & imask_q);

   // status word assembled every cycle, unused bits 14 and 8 held low
   always_comb begin
      status_d                 = PPCC_STATUS_RESET;
      status_d[PPCC_ST_TORQUE] = torque_limit_reached;
      status_d[PPCC_ST_FOLLOW] = following_error;
      status_d[PPCC_ST_ACK]    = sif.ack;
      status_d[PPCC_ST_INTLIM] = internal_limit_active;
      status_d[PPCC_ST_TARGET] = target_reached;
      status_d[PPCC_ST_REMOTE] = remote_active;
      status_d[7:0]            = drive_state_flags;
   end

   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_q    <= PPCC_CMD_RESET;
         status_q <= PPCC_STATUS_RESET;
         stop_q   <= PPCC_STOP_RESET;
         istat_q  <= PPCC_IRQ_RESET;
         imask_q  <= PPCC_IRQ_RESET;
         rdata_q  <= 32'h00000000;
         err_q    <= 1'b0;
      end else begin
         cmd_q    <= cmd_d;
         status_q <= status_d;
         stop_q   <= stop_d;
         istat_q  <= istat_d;
         imask_q  <= imask_d;
         rdata_q  <= rdata_d;
         err_q    <= err_d;
      end
   end

   // outward decode of the command word
   assign halt_req    = cmd_q[PPCC_CMD_HALT];
   assign halt_method = stop_q;
   // state machine bits pass through undecoded
   assign drive_ctl_bits = {cmd_q[PPCC_CMD_FRESET], cmd_q[3:0]};
   // selection bits are the master's to settle before the start edge
   assign wrap_select               = cmd_q[PPCC_CMD_WRAP];
   assign push_select               = cmd_q[PPCC_CMD_PUSH];
   assign incremental_origin_select = cmd_q[PPCC_CMD_ORIGIN];
   assign launch             = sif.launch;
   assign launch_incremental = sif.launch_incr;
   assign launch_replace     = sif.launch_replace;
   assign prdata             = rdata_q;

   sequence s_cmd_write;
      wr_cmd;
   endsequence

   chk_halt_from_write: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(halt_req) |-> $past(wr_cmd))
      else $error("halt request rose without a command write");
   chk_cmd_store: assert property (@(posedge pclk) disable iff (!presetn)
      s_cmd_write |=> cmd_q == $past(wr_cmd_val))
      else $error("command word not stored as written");
   chk_halt_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      halt_req && !$past(halt_req) ##1 halt_req |-> !launch || $past(launch_replace)
         || $past(sif.done))
      else $error("launch while halted without a cause");
   chk_status_pack: assert property (@(posedge pclk) disable iff (!presetn)
      status_q[14] == 1'b0 && status_q[8] == 1'b0 && status_q[PPCC_ST_ACK] == $past(sif.ack))
      else $error("status word upper byte packed wrongly");
   chk_status_low: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> status_q[7:0] == $past(drive_state_flags))
      else $error("status word lower byte not the drive flags");
   chk_ack_drops: assert property (@(posedge pclk) disable iff (!presetn)
      !drive_state_flags[PPCC_DRV_OP_EN] ##1 1'b1 |=> !status_q[PPCC_ST_ACK])
      else $error("accepted flag stays set outside operation");
   chk_irq_accept: assert property (@(posedge pclk) disable iff (!presetn)
      sif.accepted && imask_q[PPCC_IRQ_ACCEPT] && !wr_imask |=> irq)
      else $error("accepted start did not raise interrupt");
   chk_read_cmd: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == PPCC_OFF_CMD |=> prdata[15:0] == cmd_q
         && drive_ctl_bits[3:0] == cmd_q[3:0])
      else $error("command word read back wrongly");
endmodule : ppcc_top

// file: inc/ppcc_pkg.sv
// shared constants and types of the profile position command block
package ppcc_pkg;
   // apb register byte addresses
   localparam logic [15:0] PPCC_OFF_CMD       = 16'h6040;
   localparam logic [15:0] PPCC_OFF_STATUS    = 16'h6044;
   localparam logic [15:0] PPCC_OFF_IRQ_STAT  = 16'h6048;
   localparam logic [15:0] PPCC_OFF_IRQ_MASK  = 16'h604c;
   localparam logic [15:0] PPCC_OFF_STOP_CFG  = 16'h6050;
   // command word fields
   localparam int unsigned PPCC_CMD_START     = 4;
   localparam int unsigned PPCC_CMD_IMMED     = 5;
   localparam int unsigned PPCC_CMD_INCR      = 6;
   localparam int unsigned PPCC_CMD_FRESET    = 7;
   localparam int unsigned PPCC_CMD_HALT      = 8;
   localparam int unsigned PPCC_CMD_ORIGIN    = 12;
   localparam int unsigned PPCC_CMD_PUSH      = 13;
   localparam int unsigned PPCC_CMD_WRAP      = 14;
   localparam logic [15:0] PPCC_CMD_MASK      = 16'h71ff;
   localparam logic [15:0] PPCC_CMD_RESET     = 16'h0000;
   // status word fields
   localparam int unsigned PPCC_ST_TORQUE     = 15;
   localparam int unsigned PPCC_ST_FOLLOW     = 13;
   localparam int unsigned PPCC_ST_ACK        = 12;
   localparam int unsigned PPCC_ST_INTLIM     = 11;
   localparam int unsigned PPCC_ST_TARGET     = 10;
   localparam int unsigned PPCC_ST_REMOTE     = 9;
   localparam int unsigned PPCC_DRV_OP_EN     = 2;
   localparam logic [15:0] PPCC_STATUS_RESET  = 16'h0000;
   // stop method selection
   localparam int unsigned PPCC_STOP_W        = 2;
   localparam logic [1:0]  PPCC_STOP_RESET    = 2'h0;
   // interrupt status and mask layout
   localparam int unsigned PPCC_IRQ_W         = 2;
   localparam int unsigned PPCC_IRQ_ACCEPT    = 0;
   localparam int unsigned PPCC_IRQ_IGNORE    = 1;
   localparam logic [1:0]  PPCC_IRQ_RESET     = 2'h0;
   localparam int unsigned PPCC_SYNC_STAGES   = 2;
   // stored command state
   typedef enum logic {
      ppcc_none,
      ppcc_held
   } ppcc_pend_t;
endpackage : ppcc_pkg

// file: inc/ppcc_start_if.sv
// signals between the register side and the start controller
`timescale 1ns/100ps
interface ppcc_start_if;
   logic start_bit;
   logic immed_bit;
   logic incr_bit;
   logic halt_bit;
   logic stop_active;
   logic op_enabled;
   logic excited;
   logic busy;
   logic done;
   logic launch;
   logic launch_incr;
   logic launch_replace;
   logic accepted;
   logic ignored;
   logic ack;
   modport ctrl (input start_bit, immed_bit, incr_bit, halt_bit, stop_active, op_enabled,
                 excited, busy, done,
                 output launch, launch_incr, launch_replace, accepted, ignored, ack);
   modport regs (output start_bit, immed_bit, incr_bit, halt_bit, stop_active, op_enabled,
                 excited, busy, done,
                 input launch, launch_incr, launch_replace, accepted, ignored, ack);
endinterface : ppcc_start_if

// file: design/ppcc_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module ppcc_sync
   import ppcc_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds the second only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule : ppcc_sync

// file: design/ppcc_start_ctrl.sv
// start trigger edge, acceptance, stored or immediate command launch
`timescale 1ns/100ps
module ppcc_start_ctrl
   import ppcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   ppcc_start_if.ctrl sif
);
   logic       prev_q,       prev_d;
   logic       launch_q,     launch_d;
   logic       incr_q,       incr_d;
   logic       replace_q,    replace_d;
   logic       acc_q,        acc_d;
   logic       ign_q,        ign_d;
   logic       ack_q,        ack_d;
   logic       pend_incr_q,  pend_incr_d;
   ppcc_pend_t pend_q,       pend_d;
   logic       rise;
   logic       ok;

   assign rise = sif.start_bit & ~prev_q;
   assign ok   = ~sif.halt_bit & ~sif.stop_active & sif.op_enabled & sif.excited;

   // next values of the launch and store logic
   always_comb begin
      prev_d      = sif.start_bit;
      launch_d    = 1'b0;
      incr_d      = incr_q;
      replace_d   = 1'b0;
      acc_d       = 1'b0;
      ign_d       = rise & ~ok;
      ack_d       = ack_q;
      pend_d      = pend_q;
      pend_incr_d = pend_incr_q;
      if (rise && ok) begin
         acc_d = 1'b1;
         ack_d = 1'b1;
         if (!sif.busy || sif.immed_bit) begin
            launch_d  = 1'b1;
            incr_d    = sif.incr_bit;
            replace_d = sif.busy;
            pend_d    = ppcc_none;
         end else begin
            pend_d      = ppcc_held;
            pend_incr_d = sif.incr_bit;
         end
      end else begin
         unique case (pend_q)
            ppcc_none: ;
            ppcc_held: if (sif.done && ok) begin
               launch_d = 1'b1;
               incr_d   = pend_incr_q;
               pend_d   = ppcc_none;
            end
         endcase
      end
      // a halt or leaving operation drops the stored command
      if (sif.halt_bit || !sif.op_enabled) begin
         pend_d = ppcc_none;
      end
      if (!sif.start_bit || !sif.op_enabled) begin
         ack_d = 1'b0;
      end
   end

   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q      <= 1'b0;
         launch_q    <= 1'b0;
         incr_q      <= 1'b0;
         replace_q   <= 1'b0;
         acc_q       <= 1'b0;
         ign_q       <= 1'b0;
         ack_q       <= 1'b0;
         pend_q      <= ppcc_none;
         pend_incr_q <= 1'b0;
      end else begin
         prev_q      <= prev_d;
         launch_q    <= launch_d;
         incr_q      <= incr_d;
         replace_q   <= replace_d;
         acc_q       <= acc_d;
         ign_q       <= ign_d;
         ack_q       <= ack_d;
         pend_q      <= pend_d;
         pend_incr_q <= pend_incr_d;
      end
   end

   assign sif.launch         = launch_q;
   assign sif.launch_incr    = incr_q;
   assign sif.launch_replace = replace_q;
   assign sif.accepted       = acc_q;
   assign sif.ignored        = ign_q;
   assign sif.ack            = ack_q;

   sequence s_stored;
      rise && ok && sif.busy && !sif.immed_bit;
   endsequence

   chk_abs_select: assert property (@(posedge pclk) disable iff (!presetn)
      rise && ok && !sif.busy && !sif.incr_bit |=> launch_q && !incr_q)
      else $error("absolute start not launched as absolute");
   chk_incr_select: assert property (@(posedge pclk) disable iff (!presetn)
      rise && ok && !sif.busy && sif.incr_bit |=> launch_q && incr_q)
      else $error("incremental start not launched as incremental");
   chk_stored_waits: assert property (@(posedge pclk) disable iff (!presetn)
      s_stored |=> !launch_q && pend_q == ppcc_held)
      else $error("buffered start launched before completion");
   chk_stored_runs: assert property (@(posedge pclk) disable iff (!presetn)
      pend_q == ppcc_held && sif.done && ok && !rise |=> launch_q)
      else $error("stored command not launched on completion");
   chk_immediate_swap: assert property (@(posedge pclk) disable iff (!presetn)
      rise && ok && sif.busy && sif.immed_bit |=> launch_q && replace_q)
      else $error("immediate start did not replace running command");
   chk_start_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      rise && !ok |=> ign_q && !launch_q && !acc_q)
      else $error("start taken although refused");
   chk_ack_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      (rise && ok |=> ack_q) and (!sif.start_bit |=> !ack_q))
      else $error("command accepted flag wrong");
endmodule : ppcc_start_ctrl

// file: bench/ppcc_motion_model.sv
// motion stage model: answers launch pulses with busy and a done pulse
`timescale 1ns/100ps
module ppcc_motion_model #(
   parameter int unsigned RUN_CYC = 30
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic launch,
   output logic      motion_busy,
   output logic      motion_done
);
   int unsigned left_q;
   // any launch, replacing or fresh, restarts the run
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_q <= 0;
         motion_busy <= 1'b0;
         motion_done <= 1'b0;
      end else begin
         motion_done <= 1'b0;
         if (launch) begin
            left_q <= RUN_CYC;
            motion_busy <= 1'b1;
         end else if (left_q == 1) begin
            left_q <= 0;
            motion_busy <= 1'b0;
            motion_done <= 1'b1;
         end else if (left_q != 0) begin
            left_q <= left_q - 1;
         end
      end
   end
endmodule : ppcc_motion_model

// file: bench/profile_position_command_control_bench.sv
// self-checking bench of the profile position command block
`timescale 1ns/100ps
module profile_position_command_control_bench;
   import ppcc_pkg::*;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        stop_pin, excited, torque, follow, intlim, tgt, remote;
   logic [7:0]  flags;
   logic        busy, done, halt_req, wrap_s, push_s, orig_s;
   logic        launch, l_inc, l_rep, irq, last_inc, last_rep;
   logic [1:0]  hmeth;
   logic [4:0]  dctl;
   int          fails, total_checks, n_launch;

   ppcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_stop_pin(stop_pin), .motor_excited(excited),
      .drive_state_flags(flags), .motion_busy(busy), .motion_done(done),
      .torque_limit_reached(torque), .following_error(follow),
      .internal_limit_active(intlim), .target_reached(tgt), .remote_active(remote),
      .halt_req(halt_req), .halt_method(hmeth), .drive_ctl_bits(dctl),
      .wrap_select(wrap_s), .push_select(push_s), .incremental_origin_select(orig_s),
      .launch(launch), .launch_incremental(l_inc), .launch_replace(l_rep), .irq(irq));
   ppcc_motion_model u_model (.pclk(pclk), .presetn(presetn), .launch(launch),
      .motion_busy(busy), .motion_done(done));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // launch pulses counted mid-cycle, where they are settled
   always @(negedge pclk) begin
      if (launch === 1'b1) begin
         n_launch++;
         last_inc = l_inc;
         last_rep = l_rep;
      end
   end

   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   // one apb transfer; an idle edge first avoids double drives
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fails++;
         tally_and_finish;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   // bounded wait for the next launch, then its qualifiers
   task exp_launch(input int lim, input logic inc, input logic rep);
      int n0, n;
      n0 = n_launch;
      n = 0;
      while (n_launch == n0 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      `CHK(n_launch, n0 + 1)
      if (n_launch == n0) tally_and_finish;
      `CHK(last_inc, inc)
      `CHK(last_rep, rep)
   endtask : exp_launch
   task exp_none(input int n);
      int n0;
      n0 = n_launch;
      cyc(n);
      `CHK(n_launch, n0)
   endtask : exp_none
   task idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      // a move that never ends is a mismatch, not a quiet stop
      if (busy !== 1'b0) begin
         fails++;
         tally_and_finish;
      end
   endtask : idle

   // accepted start, status layout, interrupt and acknowledge drop
   task t_accept;
      apb(1'b1, PPCC_OFF_IRQ_MASK, 32'h3);
      apb(1'b1, PPCC_OFF_CMD, 32'h40); // selection before the trigger
      apb(1'b1, PPCC_OFF_CMD, 32'h50);
      exp_launch(8, 1'b1, 1'b0);
      cyc(2);
      `CHK(irq, 1'b1)
      apb(1'b0, PPCC_OFF_STATUS, 32'h0);
      `CHK(rd, 32'h0000be27)
      apb(1'b1, PPCC_OFF_IRQ_STAT, 32'h3);
      cyc(1);
      `CHK(irq, 1'b0)
      apb(1'b1, PPCC_OFF_CMD, 32'h40);
      cyc(2);
      apb(1'b0, PPCC_OFF_STATUS, 32'h0);
      `CHK(rd, 32'h0000ae27)
   endtask : t_accept
   // stored start waits for completion, then an immediate one replaces
   task t_stored;
      idle;
      apb(1'b1, PPCC_OFF_CMD, 32'h10);
      exp_launch(8, 1'b0, 1'b0);
      apb(1'b1, PPCC_OFF_CMD, 32'h0);
      apb(1'b1, PPCC_OFF_CMD, 32'h50);
      exp_none(6);
      exp_launch(60, 1'b1, 1'b0);
      apb(1'b1, PPCC_OFF_CMD, 32'h20);
      apb(1'b1, PPCC_OFF_CMD, 32'h30);
      exp_launch(8, 1'b0, 1'b1);
   endtask : t_stored
   // each acceptance condition blocks a start in turn
   task t_ignore;
      idle;
      apb(1'b1, PPCC_OFF_IRQ_STAT, 32'h3);
      apb(1'b1, PPCC_OFF_CMD, 32'h100);
      cyc(1); // command outputs follow one edge after the write
      `CHK(halt_req, 1'b1)
      apb(1'b1, PPCC_OFF_CMD, 32'h110);
      exp_none(8);
      apb(1'b0, PPCC_OFF_IRQ_STAT, 32'h0);
      `CHK(rd, 32'h2)
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, PPCC_OFF_CMD, 32'h0);
         stop_pin <= (i == 0);
         excited <= (i != 1);
         flags <= (i == 2) ? 8'h23 : 8'h27;
         cyc(4); // more than two cycles after halt clears
         apb(1'b1, PPCC_OFF_CMD, 32'h10);
         exp_none(8);
      end
      apb(1'b1, PPCC_OFF_CMD, 32'h0);
      flags <= 8'h27;
      cyc(4);
      apb(1'b1, PPCC_OFF_CMD, 32'h10);
      exp_launch(8, 1'b0, 1'b0);
   endtask : t_ignore
   // pass-through bits, readback mask, stop method, unmapped place
   task t_misc;
      apb(1'b1, PPCC_OFF_CMD, 32'hfe8f);
      cyc(1);
      `CHK(dctl, 5'h1f)
      `CHK({wrap_s, push_s, orig_s}, 3'h7)
      apb(1'b0, PPCC_OFF_CMD, 32'h0);
      `CHK(rd, 32'h0000708f)
      apb(1'b1, PPCC_OFF_STOP_CFG, 32'h2);
      cyc(1);
      `CHK(hmeth, 2'h2)
      apb(1'b0, 16'h6054, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
   endtask : t_misc

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {stop_pin, n_launch, fails, total_checks} = '0;
      {excited, torque, follow, intlim, tgt, remote} = 6'h3f;
      flags = 8'h27;
      cyc(3);
      presetn <= 1'b1;
      apb(1'b0, PPCC_OFF_IRQ_MASK, 32'h0);
      `CHK(rd, 32'h0)
      t_accept;
      t_stored;
      t_ignore;
      t_misc;
      tally_and_finish;
   end
endmodule : profile_position_command_control_bench
